// ==== verilog/ptc_pkg.sv ====
// constants, field layout and state types of the periodic timer control block
package ptc_pkg;

    // ****************************************
    // register word offsets (word index, haddr[4:2])
    // ****************************************
    localparam logic [2:0] PTC_IDX_RUN   = 3'h0;
    localparam logic [2:0] PTC_IDX_MODE  = 3'h1;
    localparam logic [2:0] PTC_IDX_PERL  = 3'h2;
    localparam logic [2:0] PTC_IDX_PERH  = 3'h3;
    localparam logic [2:0] PTC_IDX_DUTYL = 3'h4;
    localparam logic [2:0] PTC_IDX_DUTYH = 3'h5;
    localparam logic [2:0] PTC_IDX_CNTL  = 3'h6;
    localparam logic [2:0] PTC_IDX_CNTH  = 3'h7;

    // ****************************************
    // field positions
    // ****************************************
    localparam int PTC_PAU_BIT   = 7;
    localparam int PTC_CK_LSB    = 4;
    localparam int PTC_ON_BIT    = 3;
    localparam int PTC_MODE_LSB  = 6;
    localparam int PTC_IO_LSB    = 4;
    localparam int PTC_OC_BIT    = 3;
    localparam int PTC_POL_BIT   = 2;
    localparam int PTC_CAPTS_BIT = 1;
    localparam int PTC_CCLR_BIT  = 0;

    // ****************************************
    // encodings and limits
    // ****************************************
    localparam logic [1:0]  PTC_MODE_CMP  = 2'h0;
    localparam logic [1:0]  PTC_MODE_CAP  = 2'h1;
    localparam logic [1:0]  PTC_MODE_PWM  = 2'h2;
    localparam logic [1:0]  PTC_MODE_TMR  = 2'h3;
    localparam logic [15:0] PTC_MAX_NARROW = 16'h03FF;
    localparam logic [15:0] PTC_MAX_WIDE   = 16'hFFFF;
    localparam logic [5:0]  PTC_DIV4_MASK  = 6'h03;
    localparam logic [5:0]  PTC_DIV16_MASK = 6'h0F;
    localparam logic [5:0]  PTC_DIV64_MASK = 6'h3F;

    // ****************************************
    // types and reset values
    // ****************************************
    typedef struct packed {
        logic       pau;
        logic [2:0] ck;
        logic       on;
        logic [1:0] mode;
        logic [1:0] io;
        logic       oc;
        logic       pol;
        logic       capts;
        logic       cclr;
    } ptc_ctrl_s;

    typedef struct packed {
        ptc_ctrl_s   ctrl;
        logic [15:0] period;
        logic [15:0] duty;
        logic [15:0] cnt;
        logic [5:0]  pre;
        logic [2:0]  sy1;
        logic [2:0]  sy2;
        logic [2:0]  sy3;
        logic        pout;
        logic        pin;
        logic        oe;
        logic        wr_pend;
        logic        rd_pend;
        logic        hit;
        logic [2:0]  idx;
        logic        hreadyout;
        logic [31:0] hrdata;
        logic        hresp;
    } ptc_state_s;

    localparam ptc_ctrl_s   PTC_CTRL_RST   = '0;
    localparam logic [15:0] PTC_PERIOD_RST = 16'h0000;
    localparam logic [15:0] PTC_DUTY_RST   = 16'h0000;
    localparam logic [15:0] PTC_CNT_RST    = 16'h0000;

endpackage

// ==== verilog/ptc_periodic_timer.sv ====
// periodic timer: control, period and duty registers, counter and pin logic
//
// The AHB-Lite slave port and the address map were left to the implementer.
`timescale 1ns/1ns
module ptc_periodic_timer
    import ptc_pkg::*;
#(
    parameter bit WIDE_VARIANT = 1'b1
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    input  wire logic        sub_clock_pin,
    input  wire logic        external_clock_pin,
    input  wire logic        capture_input_pin,
    output logic             timer_output_pin,
    output logic             timer_output_oe
);

    // ****************************************
    // width dependent limits
    // ****************************************
    // counter ceiling
    localparam logic [15:0] MAXV = WIDE_VARIANT ? PTC_MAX_WIDE : PTC_MAX_NARROW;

    ptc_state_s  s;
    ptc_state_s  n;
    logic        on_rise;
    logic        tick;
    logic        spm;
    logic        ext_rise;
    logic        ext_fall;
    logic        sub_rise;
    logic        cap_now;
    logic        cap_prev;
    logic        cap_edge;
    logic        at_max;
    logic        a_match;
    logic        p_match;
    logic        clr;
    logic        act;
    logic        lvl;
    logic [15:0] inc;

    // ****************************************
    // register read decode
    // ****************************************
    function automatic logic [7:0] reg_read(input logic [2:0] idx, input ptc_state_s st);
        logic [7:0] r;
        r = 8'h00;
        case (idx)
            PTC_IDX_RUN: begin
                r = {st.ctrl.pau, st.ctrl.ck, st.ctrl.on, 3'h0};
            end
            PTC_IDX_MODE: begin
                r = {st.ctrl.mode, st.ctrl.io, st.ctrl.oc, st.ctrl.pol, st.ctrl.capts, st.ctrl.cclr};
            end
            PTC_IDX_PERL: begin
                r = st.period[7:0];
            end
            PTC_IDX_PERH: begin
                r = st.period[15:8];
            end
            PTC_IDX_DUTYL: begin
                r = st.duty[7:0];
            end
            PTC_IDX_DUTYH: begin
                r = st.duty[15:8];
            end
            PTC_IDX_CNTL: begin
                r = st.cnt[7:0];
            end
            PTC_IDX_CNTH: begin
                r = st.cnt[15:8];
            end
            default: begin
                r = 8'h00;
            end
        endcase
        return r;
    endfunction

    // ****************************************
    // edge and prescale helpers
    // ****************************************
    function automatic logic rise_of(input logic now_v, input logic prev_v);
        return now_v & ~prev_v;
    endfunction

    function automatic logic fall_of(input logic now_v, input logic prev_v);
        return ~now_v & prev_v;
    endfunction

    // prescaler free-runs from reset, so divided ticks are not phase-aligned to the on bit
    function automatic logic pre_due(input logic [5:0] pre_v, input logic [5:0] mask_v);
        return (pre_v & mask_v) == mask_v;
    endfunction

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        n = s;
        on_rise = 1'b0;

        // ****************************************
        // pin synchronisers
        // ****************************************
        // pins pass three flops; edges only look at the second and third
        n.sy1 = {sub_clock_pin, external_clock_pin, capture_input_pin};
        n.sy2 = s.sy1;
        n.sy3 = s.sy2;
        sub_rise = rise_of(s.sy2[2], s.sy3[2]);
        ext_rise = rise_of(s.sy2[1], s.sy3[1]);
        ext_fall = fall_of(s.sy2[1], s.sy3[1]);
        n.pre = s.pre + 6'h01;

        // ****************************************
        // register bus
        // ****************************************
        // bus: writes take no wait, reads take one wait state
        n.hreadyout = 1'b1;
        n.hresp = 1'b0;
        n.wr_pend = 1'b0;
        n.rd_pend = 1'b0;
        if (s.rd_pend) begin
            n.hrdata = {24'h000000, s.hit ? reg_read(s.idx, s) : 8'h00};
        end
        if (hsel && htrans[1] && hready) begin
            n.wr_pend = hwrite;
            n.rd_pend = ~hwrite;
            n.idx = haddr[4:2];
            n.hit = (haddr[7:5] == 3'h0);
            if (!hwrite) begin
                n.hreadyout = 1'b0;
            end
        end

        if (s.wr_pend && s.hit) begin
            case (s.idx)
                PTC_IDX_RUN: begin
                    n.ctrl.pau = hwdata[PTC_PAU_BIT];
                    n.ctrl.ck = hwdata[PTC_CK_LSB +: 3];
                    n.ctrl.on = hwdata[PTC_ON_BIT];
                    on_rise = hwdata[PTC_ON_BIT] & ~s.ctrl.on;
                end
                PTC_IDX_MODE: begin
                    n.ctrl.mode = hwdata[PTC_MODE_LSB +: 2];
                    n.ctrl.io = hwdata[PTC_IO_LSB +: 2];
                    n.ctrl.oc = hwdata[PTC_OC_BIT];
                    n.ctrl.pol = hwdata[PTC_POL_BIT];
                    n.ctrl.capts = hwdata[PTC_CAPTS_BIT];
                    n.ctrl.cclr = hwdata[PTC_CCLR_BIT];
                end
                PTC_IDX_PERL: begin
                    n.period[7:0] = hwdata[7:0];
                end
                PTC_IDX_PERH: begin
                    n.period[15:8] = hwdata[7:0] & MAXV[15:8];
                end
                PTC_IDX_DUTYL: begin
                    n.duty[7:0] = hwdata[7:0];
                end
                PTC_IDX_DUTYH: begin
                    n.duty[15:8] = hwdata[7:0] & MAXV[15:8];
                end
                default: begin
                    n.hresp = 1'b0;
                end
            endcase
        end

        // ****************************************
        // counter
        // ****************************************
        // counter clock source
        case (s.ctrl.ck)
            3'h0: tick = pre_due(s.pre, PTC_DIV4_MASK);
            3'h1: tick = 1'b1;
            3'h2: tick = pre_due(s.pre, PTC_DIV16_MASK);
            3'h3: tick = pre_due(s.pre, PTC_DIV64_MASK);
            3'h4: tick = sub_rise;
            3'h5: tick = sub_rise;
            3'h6: tick = ext_rise;
            default: tick = ext_fall;
        endcase
        tick = tick & s.ctrl.on & ~s.ctrl.pau;

        // single pulse may also be armed by the external clock pin
        spm = (s.ctrl.mode == PTC_MODE_PWM) && (s.ctrl.io == 2'h3);
        if (spm && !s.ctrl.on && ext_rise) begin
            n.ctrl.on = 1'b1;
            on_rise = 1'b1;
        end

        inc = s.cnt + 16'h0001;
        at_max = (s.cnt == MAXV);
        a_match = tick && (inc == s.duty);
        p_match = tick && (inc == s.period) && (s.period != 16'h0000);

        // clear source in compare and timer modes
        if (s.ctrl.mode == PTC_MODE_CMP || s.ctrl.mode == PTC_MODE_TMR) begin
            clr = s.ctrl.cclr ? a_match : p_match;
        end else if (spm) begin
            clr = 1'b0;
        end else begin
            clr = p_match;
        end
        // a zero period lets the count run to overflow
        clr = clr | (tick && at_max);

        // restart from zero on switch on
        if (on_rise) begin
            n.cnt = PTC_CNT_RST;
            // compare mode pin back to initial level
            if (n.ctrl.mode == PTC_MODE_CMP) begin
                n.pout = n.ctrl.oc;
            end
        // a held count resumes where it stopped
        end else if (tick) begin
            n.cnt = clr ? PTC_CNT_RST : inc;
        end

        if (s.ctrl.mode == PTC_MODE_CMP && a_match && !on_rise) begin
            // driving a held level changes nothing
            case (s.ctrl.io)
                2'h1: n.pout = 1'b0;
                2'h2: n.pout = 1'b1;
                2'h3: n.pout = ~s.pout;
                default: n.pout = s.pout;
            endcase
        end

        // single pulse ends on A match by dropping the on bit
        if (spm && a_match && !on_rise) begin
            n.ctrl.on = 1'b0;
        end

        // ****************************************
        // capture
        // ****************************************
        // capture trigger source
        cap_now = s.ctrl.capts ? s.sy2[1] : s.sy2[0];
        cap_prev = s.ctrl.capts ? s.sy3[1] : s.sy3[0];
        case (s.ctrl.io)
            2'h0: cap_edge = rise_of(cap_now, cap_prev);
            2'h1: cap_edge = fall_of(cap_now, cap_prev);
            2'h2: cap_edge = cap_now ^ cap_prev;
            default: cap_edge = 1'b0;
        endcase
        // capture wins over a duty write in the same cycle
        if (s.ctrl.mode == PTC_MODE_CAP && s.ctrl.on && cap_edge) begin
            n.duty = s.cnt;
        end

        // ****************************************
        // output pin
        // ****************************************
        // pwm pin function; duty at or above period gives 100%
        case (n.ctrl.io)
            2'h0: act = 1'b0;
            2'h1: act = 1'b1;
            2'h2: act = n.ctrl.on && (n.cnt < n.duty);
            default: act = n.ctrl.on;
        endcase

        // oc is initial level or active level
        case (n.ctrl.mode)
            PTC_MODE_CMP: begin
                lvl = n.pout;
                n.oe = 1'b1;
            end
            PTC_MODE_PWM: begin
                lvl = act ? n.ctrl.oc : ~n.ctrl.oc;
                n.oe = 1'b1;
            end
            // timer and capture leave the pin alone
            default: begin
                lvl = 1'b0;
                n.oe = 1'b0;
            end
        endcase
        n.pin = n.oe & (lvl ^ n.ctrl.pol);
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
            s.ctrl <= PTC_CTRL_RST;
            s.period <= PTC_PERIOD_RST;
            s.duty <= PTC_DUTY_RST;
            s.cnt <= PTC_CNT_RST;
            s.hreadyout <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign hreadyout = s.hreadyout;
    assign hrdata = s.hrdata;
    assign hresp = s.hresp;
    assign timer_output_pin = s.pin;
    assign timer_output_oe = s.oe;

endmodule

// ==== tb/ptc_periodic_timer_assertions.sv ====
// port assertions for the periodic timer
`timescale 1ns/1ns
module ptc_periodic_timer_assertions
    import ptc_pkg::*;
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic        timer_output_pin,
    input wire logic        timer_output_oe
);
    // shadow of the control bytes, rebuilt from bus writes
    logic       wr_ph;
    logic       rd_ph;
    logic [5:0] a_ph;
    logic [7:0] md;
    logic [7:0] rn;
    logic [2:0] qt;
    logic       tk;
    logic       rd_end;
    logic       wr_ctl;
    assign tk     = hsel && htrans[1] && hready;
    assign rd_end = rd_ph && hready;
    assign wr_ctl = wr_ph && hready && a_ph < 6'h02;
    // qt counts quiet cycles since a control write, so pin checks skip the update latency
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {wr_ph, rd_ph, a_ph, md, rn, qt} <= '0;
        end else begin
            if (hready) begin
                wr_ph <= tk && hwrite;
                rd_ph <= tk && !hwrite;
                a_ph  <= haddr[7:2];
            end
            if (wr_ctl && a_ph == 6'h00) rn <= hwdata[7:0];
            if (wr_ctl && a_ph == 6'h01) md <= hwdata[7:0];
            qt <= wr_ctl ? 3'h0 : qt + {2'h0, qt != 3'h7};
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence rd_answer;
        !hreadyout ##1 hreadyout;
    endsequence
    read_wait_a: assert property (tk && !hwrite |=> rd_answer)
        else $error("read wait wrong");
    write_wait_a: assert property (tk && hwrite |=> hreadyout)
        else $error("write wait wrong");
    upper_zero_a: assert property (rd_end |-> hrdata[31:8] == 24'h000000)
        else $error("upper read bits set");
    run_unused_a: assert property (rd_end && a_ph == 6'h00 |-> hrdata[2:0] == 3'h0)
        else $error("unused run bits set");
    idle_pin_a: assert property (!timer_output_oe |-> !timer_output_pin)
        else $error("pin high while released");
    timer_float_a: assert property (qt > 3'h2 && md[7:6] == 2'h3 |-> !timer_output_oe)
        else $error("pin driven in timer mode");
    drive_on_a: assert property (qt > 3'h2 && !md[6] |-> timer_output_oe)
        else $error("pin not driven");
    forced_lvl_a: assert property (qt > 3'h2 && rn[3] && md[7:5] == 3'h4 |-> timer_output_pin == ((md[4] ? md[3] : !md[3]) ^ md[2]))
        else $error("forced level wrong");
    cmp_hold_a: assert property (qt > 3'h2 && rn[3] && md[7:4] == 4'h0 |-> timer_output_pin == (md[3] ^ md[2]))
        else $error("compare level moved");
endmodule
bind ptc_periodic_timer ptc_periodic_timer_assertions ptc_chk_i (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
    .hreadyout, .hrdata, .timer_output_pin, .timer_output_oe
);

// ==== tb/tb.sv ====
// self-checking bench for the periodic timer control block
`timescale 1ns/1ns
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; $display("Error %0t: got %0h exp %0h", $time, g, e); end end
module tb;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = '0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = '0;
    logic        sub_clock_pin = 1'b0;
    logic        external_clock_pin = 1'b0;
    logic        capture_input_pin = 1'b0;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
    logic        rsp;
    logic        timer_output_pin;
    logic        timer_output_oe;
    logic [31:0] q;
    logic [15:0] v;
    logic [15:0] w;
    logic [7:0]  m;
    logic [1:0]  io;
    logic        e;
    int          fail_count = 0;
    int          compares = 0;
    int          cyc = 0;
    int          hi;
    int          tg;
    int          i;
    int          rate [8] = '{64, 258, 16, 4, 32, 32, 16, 16};
    logic [7:0]  ra [6] = '{8'h08, 8'h0C, 8'h00, 8'h04, 8'h20, 8'h18};
    logic [7:0]  wd [6] = '{8'hA5, 8'h5A, 8'hF7, 8'hFF, 8'h77, 8'h77};
    logic [7:0]  ex [6] = '{8'hA5, 8'h5A, 8'hF0, 8'hFF, 8'h00, 8'h00};
    ptc_periodic_timer ptc_periodic_timer_i (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hreadyout, .hrdata, .hresp, .sub_clock_pin, .external_clock_pin,
        .capture_input_pin, .timer_output_pin, .timer_output_oe
    );
    always #5 hclk = ~hclk;
    // free-running sub clock and external edges; the limit cuts a hang short
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        sub_clock_pin <= cyc[2];
        external_clock_pin <= cyc[3];
        if (cyc == 20000) begin
            fail_count++;
            complete_run();
        end
    end
    task automatic bus(input logic is_wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= is_wr;
        haddr <= {24'h000000, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= {24'h000000, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
        rsp = hresp;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a);
        bus(1'b0, a, 8'h00);
    endtask
    // byte pairs are read low first; values still changing are only checked by a bound or against zero
    task automatic rd2(input logic [7:0] a);
        rd(a);
        v[7:0] = q[7:0];
        rd(a + 8'h04);
        v[15:8] = q[7:0];
    endtask
    task automatic watch(input int n);
        hi = 0;
        tg = 0;
        e = timer_output_pin;
        repeat (n) begin
            @(posedge hclk);
            #1;
            hi += (timer_output_pin === 1'b1);
            tg += (timer_output_pin !== e);
            e = timer_output_pin;
        end
    endtask
    task automatic complete_run();
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        for (i = 0; i < 8; i++) begin
            rd(8'(i * 4));
            `CHK(q, 32'h0)
        end
        for (i = 0; i < 6; i++) wr(ra[i], wd[i]);
        for (i = 0; i < 6; i++) begin
            rd(ra[i]);
            `CHK(q, {24'h0, ex[i]})
            `CHK(rsp, 1'b0)
        end
        $display("test registers done");
        wr(8'h08, 8'h00);
        wr(8'h0C, 8'h00);
        wr(8'h04, 8'hC0);
        for (i = 0; i < 8; i++) begin
            wr(8'h00, 8'(i * 16 + 8));
            repeat (256) @(posedge hclk);
            wr(8'h00, 8'(i * 16 + 136));
            rd2(8'h18);
            `CHK((v + 4 >= rate[i]) && (v <= rate[i] + 4), 1'b1)
            wr(8'h00, 8'h00);
        end
        wr(8'h00, 8'h18);
        repeat (40) @(posedge hclk);
        wr(8'h00, 8'h98);
        rd2(8'h18);
        w = v;
        repeat (20) @(posedge hclk);
        rd2(8'h18);
        `CHK(v, w)
        wr(8'h00, 8'h18);
        repeat (40) @(posedge hclk);
        wr(8'h00, 8'h98);
        rd2(8'h18);
        `CHK(v >= w + 16'd40, 1'b1)
        wr(8'h00, 8'h10);
        rd2(8'h18);
        w = v;
        repeat (30) @(posedge hclk);
        rd2(8'h18);
        `CHK({v == w, v > 16'd80}, 2'h3)
        wr(8'h00, 8'h18);
        rd2(8'h18);
        `CHK(v < 16'd16, 1'b1)
        $display("test counter done");
        wr(8'h10, 8'h08);
        wr(8'h14, 8'h00);
        for (i = 0; i < 17; i++) begin
            io = 2'(i / 4);
            if (i < 12) m = {2'h0, io, i[1], i[0], 2'h1};
            else if (i < 16) m = {3'h4, i[1], i[0], 3'h1};
            else m = 8'hEC;
            e = (i < 12) ? (((io == 2'h0) ? i[1] : io[1]) ^ i[0]) : ((i < 16) && (i[1] == i[0]));
            wr(8'h00, 8'h10);
            wr(8'h04, m);
            wr(8'h00, 8'h18);
            repeat (2) @(posedge hclk);
            #1;
            if (i < 12) `CHK(timer_output_pin, i[1] ^ i[0])
            repeat (30) @(posedge hclk);
            #1;
            `CHK(timer_output_pin, e)
            `CHK(timer_output_oe, i < 16)
        end
        wr(8'h08, 8'h10);
        for (i = 0; i < 2; i++) begin
            wr(8'h00, 8'h10);
            wr(8'h04, 8'(8'h30 + i));
            wr(8'h00, 8'h18);
            watch(80);
            `CHK((tg >= 4 + 5 * i) && (tg <= 6 + 5 * i), 1'b1)
        end
        // clear select set here must not shorten the pwm period
        wr(8'h00, 8'h10);
        wr(8'h04, 8'hA9);
        wr(8'h00, 8'h18);
        watch(160);
        `CHK((hi >= 76) && (hi <= 84), 1'b1)
        wr(8'h08, 8'h00);
        // single pulse ignores the period; each external rising edge re-arms it after the pulse
        wr(8'h00, 8'h10);
        wr(8'h04, 8'hB8);
        wr(8'h00, 8'h18);
        watch(160);
        `CHK((hi >= 64) && (hi <= 96), 1'b1)
        $display("test output pin done");
        for (i = 0; i < 5; i++) begin
            wr(8'h00, 8'h10);
            wr(8'h04, (i < 4) ? {2'h1, 2'(i), 4'h0} : 8'h42);
            wr(8'h10, 8'h00);
            wr(8'h14, 8'h00);
            wr(8'h00, 8'h18);
            repeat (40) @(posedge hclk);
            rd2(8'h10);
            `CHK(v === 16'h0, i < 4)
            capture_input_pin <= !capture_input_pin;
            repeat (10) @(posedge hclk);
            rd2(8'h10);
            `CHK(v === 16'h0, i == 3)
        end
        $display("test capture done");
        complete_run();
    end
endmodule
